// file: logic/dscr_regs.svh
// Register offsets, field positions, reset values and timing figures
`ifndef DSCR_REGS_SVH
`define DSCR_REGS_SVH

`define DSCR_CLK_NS          10

`define DSCR_ADDR_PMOP       8'h01
`define DSCR_ADDR_DATA       8'h21
`define DSCR_ADDR_HIGH       8'h25
`define DSCR_ADDR_LOW        8'h26
`define DSCR_ADDR_PMSTAT     8'h78
`define DSCR_ADDR_PMREV      8'h98
`define DSCR_ADDR_STATUS     8'hd0
`define DSCR_ADDR_CONFIG     8'hd1
`define DSCR_ADDR_TRIGGER    8'hd3

`define DSCR_ST_USER_ALARM   15
`define DSCR_ST_FACT_ALARM   14
`define DSCR_ST_NV_BUSY      13
`define DSCR_ST_UPD_BUSY     12

`define DSCR_CF_WAVE_HI      15
`define DSCR_CF_WAVE_LO      14
`define DSCR_CF_LOCK         13
`define DSCR_CF_PMBUS        12
`define DSCR_CF_STEP_HI      11
`define DSCR_CF_STEP_LO      9
`define DSCR_CF_SLEW_HI      8
`define DSCR_CF_SLEW_LO      5
`define DSCR_CF_PDN_HI       4
`define DSCR_CF_PDN_LO       3
`define DSCR_CF_REF          2
`define DSCR_CF_SPAN_HI      1
`define DSCR_CF_SPAN_LO      0
`define DSCR_CF_RESET        16'h01f0
`define DSCR_CF_KEEP_MASK    16'hdfff

`define DSCR_TR_UNLOCK_HI    15
`define DSCR_TR_UNLOCK_LO    12
`define DSCR_TR_CFG_RESET    9
`define DSCR_TR_RUN          8
`define DSCR_TR_MARGIN_HIGH  7
`define DSCR_TR_MARGIN_LOW   6
`define DSCR_TR_NV_RELOAD    5
`define DSCR_TR_NV_PROG      4
`define DSCR_UNLOCK_CODE     4'h5

`define DSCR_CODE_LSB        2
`define DSCR_SLEW_NONE       4'hf

`define DSCR_SLEW_FAST_NS    25600
`define DSCR_SLEW_MID_NS     204800
`define DSCR_SLEW_SLOW_NS    1638400
`define DSCR_SLEW_12US_NS    12000
`define DSCR_SLEW_8US_NS     8000
`define DSCR_SLEW_4US_NS     4000
`define DSCR_NV_BUSY_NS      20000

`endif

// file: logic/dscr_pkg.sv
// Types shared by the converter register bank
`default_nettype none
package dscr_pkg;
	typedef enum logic [1:0] {WV_TRIANGLE, WV_SAW_UP, WV_SAW_DOWN, WV_SQUARE} dscr_wave_sel_type;
	typedef enum {ST_FOLLOW, ST_RISE, ST_FALL} dscr_wave_state_type;
endpackage : dscr_pkg
`default_nettype wire

// file: logic/dscr_step_if.sv
// Settings and state passed between register bank and waveform generator
`timescale 1ns/1ps
`default_nettype none
interface dscr_step_if import dscr_pkg::*; #(parameter int CODE_W = 10);
	dscr_wave_sel_type   mode;
	logic                run;
	logic [3:0]          slewSel;
	logic [2:0]          stepSel;
	logic [CODE_W-1:0]   highCode;
	logic [CODE_W-1:0]   lowCode;
	logic [CODE_W-1:0]   targetCode;
	logic [CODE_W-1:0]   code;
	logic                busy;
	modport ctrl (output mode, run, slewSel, stepSel, highCode, lowCode, targetCode,
		input code, busy);
	modport gen (input mode, run, slewSel, stepSel, highCode, lowCode, targetCode,
		output code, busy);
endinterface : dscr_step_if
`default_nettype wire

// file: logic/dscr_wave_gen.sv
// Slew stepping and waveform generator for the output code
`timescale 1ns/1ps
`default_nettype none
`include "dscr_regs.svh"
module dscr_wave_gen import dscr_pkg::*; #(
	parameter int CODE_W   = 10,
	parameter int FAST_CYC = 2560,
	parameter int MID_CYC  = 20480,
	parameter int SLOW_CYC = 163840
) (
	input  wire logic  clk_sys,
	input  wire logic  rst,
	dscr_step_if.gen   step
);
	localparam int C12 = (`DSCR_SLEW_12US_NS + `DSCR_CLK_NS - 1) / `DSCR_CLK_NS;
	localparam int C8  = (`DSCR_SLEW_8US_NS + `DSCR_CLK_NS - 1) / `DSCR_CLK_NS;
	localparam int C4  = (`DSCR_SLEW_4US_NS + `DSCR_CLK_NS - 1) / `DSCR_CLK_NS;

	dscr_wave_state_type state;
	dscr_wave_state_type next_state;
	logic [23:0]         tickCnt;
	logic [23:0]         periodCyc;
	logic [CODE_W-1:0]   next_code;
	logic [CODE_W:0]     stepExt;
	logic [CODE_W:0]     upSum;
	logic [CODE_W:0]     downDiff;
	logic                tick;
	logic                noSlew;

	// Cycles per step from the slew field
	function automatic logic [23:0] period_for(input logic [3:0] sel);
		logic [23:0] base;
		base = 24'(FAST_CYC);
		case (sel[3:2])
			2'h0: base = 24'(FAST_CYC);
			2'h1: base = 24'(MID_CYC);
			2'h2: base = 24'(SLOW_CYC);
			default: base = 24'(C4);
		endcase
		if (sel[3:2] == 2'h3) begin
			case (sel[1:0])
				2'h0: period_for = 24'(C12);
				2'h1: period_for = 24'(C8);
				default: period_for = 24'(C4);
			endcase
		end else begin
			period_for = base + ((base * 24'(sel[1:0])) >> 2);
		end
	endfunction : period_for

	// Code step size from the step field
	function automatic logic [5:0] step_for(input logic [2:0] sel);
		case (sel)
			3'h0: step_for = 6'h01;
			3'h1: step_for = 6'h02;
			3'h2: step_for = 6'h03;
			3'h3: step_for = 6'h04;
			3'h4: step_for = 6'h06;
			3'h5: step_for = 6'h08;
			3'h6: step_for = 6'h10;
			default: step_for = 6'h20;
		endcase
	endfunction : step_for

	assign noSlew    = step.slewSel == `DSCR_SLEW_NONE;
	assign periodCyc = period_for(step.slewSel);
	assign tick      = noSlew || (tickCnt >= periodCyc - 24'h1);
	assign stepExt   = (CODE_W + 1)'(step_for(step.stepSel));
	assign upSum     = {1'b0, step.code} + stepExt;
	assign downDiff  = {1'b0, step.code} - stepExt;

	always_comb begin
		next_state = state;
		next_code  = step.code;
		if (!step.run) begin
			next_state = ST_FOLLOW;
			if (noSlew) begin
				next_code = step.targetCode;
			end else if (tick) begin
				if (step.code < step.targetCode) begin
					next_code = (upSum >= {1'b0, step.targetCode}) ? step.targetCode
						: upSum[CODE_W-1:0];
				end else if (downDiff[CODE_W] || downDiff < {1'b0, step.targetCode}) begin
					next_code = step.targetCode;
				end else begin
					next_code = downDiff[CODE_W-1:0];
				end
			end
		end else if (state == ST_FOLLOW) begin
			if (step.mode == WV_SAW_DOWN) begin
				next_code  = step.highCode;
				next_state = ST_FALL;
			end else begin
				next_code  = step.lowCode;
				next_state = ST_RISE;
			end
		end else if (tick) begin
			case (state)
				ST_RISE: begin
					if (step.mode == WV_SQUARE) begin
						next_code  = step.highCode;
						next_state = ST_FALL;
					end else if (step.code >= step.highCode) begin
						if (step.mode == WV_SAW_UP) begin
							next_code = step.lowCode;
						end else begin
							next_state = ST_FALL;
						end
					end else begin
						next_code = (upSum >= {1'b0, step.highCode}) ? step.highCode
							: upSum[CODE_W-1:0];
					end
				end
				ST_FALL: begin
					if (step.mode == WV_SQUARE) begin
						next_code  = step.lowCode;
						next_state = ST_RISE;
					end else if (step.code <= step.lowCode) begin
						if (step.mode == WV_SAW_DOWN) begin
							next_code = step.highCode;
						end else begin
							next_state = ST_RISE;
						end
					end else if (downDiff[CODE_W] || downDiff < {1'b0, step.lowCode}) begin
						next_code = step.lowCode;
					end else begin
						next_code = downDiff[CODE_W-1:0];
					end
				end
				default: next_state = ST_FOLLOW;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || tick || (step.run && state == ST_FOLLOW)) begin
			tickCnt <= 24'h0;
		end else begin
			tickCnt <= tickCnt + 24'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state     <= ST_FOLLOW;
			step.code <= '0;
			step.busy <= 1'b0;
		end else begin
			state     <= next_state;
			step.code <= next_code;
			step.busy <= !step.run && (next_code != step.targetCode);
		end
	end
endmodule : dscr_wave_gen
`default_nettype wire

// file: logic/dscr_status_config_regs.sv
// Status and configuration register bank of the voltage-output converter
// Summary of operation
// - Status word sits at command D0h and ignores every write.
// - Status bit 15 shows a checksum mismatch in the user store.
// - Status bit 14 shows a checksum mismatch in the factory store.
// - Status bit 13 is high during store program or reload; host waits.
// - Busy clears when the store operation ends; converter writes resume.
// - Status bit 12 is high while output update runs; host waits.
// - General configuration sits at D1h, resets to 01F0h.
// - Select 00 ramps up and down between margin codes.
// - Select 01 ramps up from low to high, then jumps low.
// - Select 10 ramps down from high to low, then jumps high.
// - Select 11 alternates margin codes, dwell set by slew field.
// - Writing 1 to config bit 13 locks all registers.
// - Unlock code 0101 in trigger bits 15:12 clears the lock.
// - Config bit 12 enables PMBus mode, reset value 0.
// - Reads return upper data byte first, then lower data byte.
// - Slew field resets to 1111, meaning code changes apply at once.
// - Waveform runs only while the trigger run bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "dscr_regs.svh"
module dscr_status_config_regs import dscr_pkg::*; #(
	parameter int         CODE_W      = 10,
	parameter int         FAST_CYC    = `DSCR_SLEW_FAST_NS / `DSCR_CLK_NS,
	parameter int         MID_CYC     = `DSCR_SLEW_MID_NS / `DSCR_CLK_NS,
	parameter int         SLOW_CYC    = `DSCR_SLEW_SLOW_NS / `DSCR_CLK_NS,
	parameter int         NV_BUSY_CYC = `DSCR_NV_BUSY_NS / `DSCR_CLK_NS,
	// Identification values are arbitrary
	parameter logic [3:0] PART_ID     = 4'h3,
	parameter logic [1:0] REVISION_ID = 2'h1,
	parameter logic [7:0] PMBUS_REV   = 8'h11
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         cmdValid,
	input  wire logic         cmdWrite,
	input  wire logic [7:0]   cmdAddr,
	input  wire logic [15:0]  cmdData,
	input  wire logic         byteAck,
	input  wire logic         userChecksumBad,
	input  wire logic         factoryChecksumBad,
	output logic [7:0]        rdByte,
	output logic              rdByteValid,
	output logic [CODE_W-1:0] dacCode,
	output logic              pmbusEnable,
	output logic              deviceLocked,
	output logic [1:0]        powerDownMode,
	output logic              refEnable,
	output logic [1:0]        outputSpan
);
	localparam int HI = `DSCR_CODE_LSB + CODE_W - 1;

	logic [15:0]  cfgReg;
	logic [15:0]  dataReg;
	logic [15:0]  highReg;
	logic [15:0]  lowReg;
	logic [15:0]  cfgStore;
	logic [15:0]  dataStore;
	logic [15:0]  highStore;
	logic [15:0]  lowStore;
	logic [7:0]   pmopReg;
	logic         lockReg;
	logic         runReg;
	logic         marginHigh;
	logic         marginLow;
	logic         nvBusy;
	logic         nvProg;
	logic [23:0]  nvCnt;
	logic [7:0]   rdLow;
	logic         rdPending;

	wire          wrEn;
	wire          hitStatus;
	wire          hitCfg;
	wire          hitTrig;
	wire          hitData;
	wire          hitHigh;
	wire          hitLow;
	wire          hitPmop;
	wire          hitPmstat;
	wire          hitPmrev;
	wire          unlockHit;
	wire          wrOpen;
	wire          dacBusy;
	wire          wrDac;
	wire          cfgWr;
	wire          dataWr;
	wire          highWr;
	wire          lowWr;
	wire          trigWr;
	wire          cfgReset;
	wire          nvStart;
	wire          nvDone;
	wire          rdStart;
	wire [15:0]   statusWord;
	wire [15:0]   readWord;

	dscr_step_if #(.CODE_W(CODE_W)) step ();

	// Address decode
	assign wrEn      = cmdValid && cmdWrite;
	assign rdStart   = cmdValid && !cmdWrite;
	assign hitStatus = cmdAddr == `DSCR_ADDR_STATUS;
	assign hitCfg    = cmdAddr == `DSCR_ADDR_CONFIG;
	assign hitTrig   = cmdAddr == `DSCR_ADDR_TRIGGER;
	assign hitData   = cmdAddr == `DSCR_ADDR_DATA;
	assign hitHigh   = cmdAddr == `DSCR_ADDR_HIGH;
	assign hitLow    = cmdAddr == `DSCR_ADDR_LOW;
	assign hitPmop   = cmdAddr == `DSCR_ADDR_PMOP;
	assign hitPmstat = cmdAddr == `DSCR_ADDR_PMSTAT;
	assign hitPmrev  = cmdAddr == `DSCR_ADDR_PMREV;

	// Write gating
	assign unlockHit = wrEn && hitTrig
		&& cmdData[`DSCR_TR_UNLOCK_HI:`DSCR_TR_UNLOCK_LO] == `DSCR_UNLOCK_CODE;
	assign wrOpen    = wrEn && !lockReg;
	assign dacBusy   = nvBusy || step.busy;
	assign wrDac     = wrOpen && !dacBusy;
	assign cfgWr     = wrDac && hitCfg;
	assign dataWr    = wrDac && hitData;
	assign highWr    = wrDac && hitHigh;
	assign lowWr     = wrDac && hitLow;
	assign trigWr    = wrOpen && hitTrig;
	assign cfgReset  = trigWr && cmdData[`DSCR_TR_CFG_RESET];
	assign nvStart   = trigWr && !dacBusy
		&& (cmdData[`DSCR_TR_NV_PROG] || cmdData[`DSCR_TR_NV_RELOAD]);
	assign nvDone    = nvBusy && nvCnt == 24'h1;

	// Read data
	assign statusWord = {userChecksumBad, factoryChecksumBad, nvBusy, step.busy, 6'h00,
		PART_ID, REVISION_ID};
	assign readWord =
		hitStatus ? statusWord :
		hitCfg    ? (cfgReg & `DSCR_CF_KEEP_MASK) :
		hitTrig   ? {8'h00, marginHigh, marginLow, 6'h00} :
		hitData   ? dataReg :
		hitHigh   ? highReg :
		hitLow    ? lowReg :
		hitPmop   ? {pmopReg, 8'h00} :
		hitPmstat ? {6'h00, nvBusy, step.busy, 8'h00} :
		hitPmrev  ? {PMBUS_REV, 8'h00} : 16'h0000;

	// Generator settings
	assign step.mode       = dscr_wave_sel_type'(cfgReg[`DSCR_CF_WAVE_HI:`DSCR_CF_WAVE_LO]);
	assign step.run        = runReg;
	assign step.slewSel    = cfgReg[`DSCR_CF_SLEW_HI:`DSCR_CF_SLEW_LO];
	assign step.stepSel    = cfgReg[`DSCR_CF_STEP_HI:`DSCR_CF_STEP_LO];
	assign step.highCode   = highReg[HI:`DSCR_CODE_LSB];
	assign step.lowCode    = lowReg[HI:`DSCR_CODE_LSB];
	assign step.targetCode = marginHigh ? highReg[HI:`DSCR_CODE_LSB]
		: marginLow ? lowReg[HI:`DSCR_CODE_LSB] : dataReg[HI:`DSCR_CODE_LSB];

	dscr_wave_gen #(
		.CODE_W   (CODE_W),
		.FAST_CYC (FAST_CYC),
		.MID_CYC  (MID_CYC),
		.SLOW_CYC (SLOW_CYC)
	) u_wave (
		.clk_sys (clk_sys),
		.rst     (rst),
		.step    (step)
	);

	// Outputs
	assign dacCode       = step.code;
	assign pmbusEnable   = cfgReg[`DSCR_CF_PMBUS];
	assign deviceLocked  = lockReg;
	assign powerDownMode = cfgReg[`DSCR_CF_PDN_HI:`DSCR_CF_PDN_LO];
	assign refEnable     = cfgReg[`DSCR_CF_REF];
	assign outputSpan    = cfgReg[`DSCR_CF_SPAN_HI:`DSCR_CF_SPAN_LO];

	// Working registers
	always_ff @(posedge clk_sys) begin
		if (rst || cfgReset) begin
			cfgReg  <= `DSCR_CF_RESET;
			dataReg <= 16'h0000;
			highReg <= 16'h0000;
			lowReg  <= 16'h0000;
		end else if (nvDone && !nvProg) begin
			cfgReg  <= cfgStore;
			dataReg <= dataStore;
			highReg <= highStore;
			lowReg  <= lowStore;
		end else begin
			if (cfgWr) begin
				cfgReg <= cmdData & `DSCR_CF_KEEP_MASK;
			end
			if (dataWr) begin
				dataReg <= cmdData;
			end
			if (highWr) begin
				highReg <= cmdData;
			end
			if (lowWr) begin
				lowReg <= cmdData;
			end
		end
	end

	// Lock bit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lockReg <= 1'b0;
		end else if (unlockHit) begin
			lockReg <= 1'b0;
		end else if (cfgWr && cmdData[`DSCR_CF_LOCK]) begin
			lockReg <= 1'b1;
		end
	end

	// Nonvolatile copy
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfgStore  <= `DSCR_CF_RESET;
			dataStore <= 16'h0000;
			highStore <= 16'h0000;
			lowStore  <= 16'h0000;
		end else if (nvDone && nvProg) begin
			cfgStore  <= cfgReg;
			dataStore <= dataReg;
			highStore <= highReg;
			lowStore  <= lowReg;
		end
	end

	// Store operation timer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nvBusy <= 1'b0;
			nvProg <= 1'b0;
			nvCnt  <= 24'h0;
		end else if (nvStart) begin
			nvBusy <= 1'b1;
			nvProg <= cmdData[`DSCR_TR_NV_PROG];
			nvCnt  <= 24'(NV_BUSY_CYC);
		end else if (nvDone) begin
			nvBusy <= 1'b0;
			nvCnt  <= 24'h0;
		end else if (nvBusy) begin
			nvCnt  <= nvCnt - 24'h1;
		end
	end

	// Trigger bits; a write setting a margin bit wins over its self clear
	always_ff @(posedge clk_sys) begin
		if (rst || cfgReset) begin
			runReg     <= 1'b0;
			marginHigh <= 1'b0;
			marginLow  <= 1'b0;
			pmopReg    <= 8'h00;
		end else begin
			if (trigWr) begin
				runReg <= cmdData[`DSCR_TR_RUN];
			end
			if (trigWr && !dacBusy && cmdData[`DSCR_TR_MARGIN_HIGH]) begin
				marginHigh <= 1'b1;
				marginLow  <= 1'b0;
			end else if (trigWr && !dacBusy && cmdData[`DSCR_TR_MARGIN_LOW]) begin
				marginLow  <= 1'b1;
				marginHigh <= 1'b0;
			end else if (!step.busy && step.code == step.targetCode && !runReg) begin
				marginHigh <= 1'b0;
				marginLow  <= 1'b0;
			end
			if (wrOpen && hitPmop) begin
				pmopReg <= cmdData[15:8];
			end
		end
	end

	// Byte read-out, upper byte first
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdByte      <= 8'h00;
			rdByteValid <= 1'b0;
			rdLow       <= 8'h00;
			rdPending   <= 1'b0;
		end else if (rdStart) begin
			rdByte      <= readWord[15:8];
			rdLow       <= readWord[7:0];
			rdByteValid <= 1'b1;
			rdPending   <= 1'b1;
		end else if (byteAck && rdPending) begin
			rdByte      <= rdLow;
			rdByteValid <= 1'b1;
			rdPending   <= 1'b0;
		end else begin
			rdByteValid <= 1'b0;
		end
	end
endmodule : dscr_status_config_regs
`default_nettype wire

// file: tb/dscr_status_config_regs_asserts.sv
// Port checks for the converter register bank
`timescale 1ns/1ps
`default_nettype none
module dscr_regs_checker #(
	parameter int         CODE_W      = 10,
	parameter logic [3:0] PART_ID     = 4'h3,
	parameter logic [1:0] REVISION_ID = 2'h1
) (
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              cmdValid,
	input wire logic              cmdWrite,
	input wire logic [7:0]        cmdAddr,
	input wire logic [15:0]       cmdData,
	input wire logic              byteAck,
	input wire logic              userChecksumBad,
	input wire logic              factoryChecksumBad,
	input wire logic [7:0]        rdByte,
	input wire logic              rdByteValid,
	input wire logic [CODE_W-1:0] dacCode,
	input wire logic              pmbusEnable,
	input wire logic              deviceLocked,
	input wire logic [1:0]        powerDownMode,
	input wire logic              refEnable,
	input wire logic [1:0]        outputSpan
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire rdCmd     = cmdValid && !cmdWrite;
	wire statusRd  = rdCmd && cmdAddr == 8'hd0;
	wire unlockCmd = cmdValid && cmdWrite && cmdAddr == 8'hd3 && cmdData[15:12] == 4'h5;
	wire lockCmd   = cmdValid && cmdWrite && cmdAddr == 8'hd1 && cmdData[13];

	AST_RD_UPPER: assert property (rdCmd |=> rdByteValid)
		else $error("read gave no upper byte");
	AST_BYTE_CAUSE: assert property (rdByteValid |-> $past(rdCmd) || $past(byteAck))
		else $error("byte without a cause");
	AST_ALARMS: assert property (statusRd |=> rdByte[7:6] == $past({userChecksumBad, factoryChecksumBad}))
		else $error("alarm bits wrong");
	AST_STATUS_ID: assert property (statusRd ##1 !cmdValid ##1 (byteAck && !cmdValid) |=> rdByte == {2'b00, PART_ID, REVISION_ID})
		else $error("status lower byte wrong");
	AST_RESET_CFG: assert property ($fell(rst) |-> !pmbusEnable && !deviceLocked && powerDownMode == 2'b10 && !refEnable && outputSpan == 2'b00)
		else $error("config outputs not at reset");
	AST_LOCK_CAUSE: assert property ($rose(deviceLocked) |-> $past(lockCmd))
		else $error("lock set without a lock write");
	AST_LOCK_HOLD: assert property (deviceLocked && !unlockCmd |=> deviceLocked)
		else $error("lock dropped without unlock");
	AST_UNLOCK: assert property (deviceLocked && unlockCmd |=> !deviceLocked)
		else $error("unlock code ignored");
	AST_LOCK_FREEZE: assert property (deviceLocked |=> $stable({pmbusEnable, powerDownMode, refEnable, outputSpan}))
		else $error("config changed while locked");
endmodule : dscr_regs_checker
bind dscr_status_config_regs dscr_regs_checker #(.CODE_W(CODE_W), .PART_ID(PART_ID), .REVISION_ID(REVISION_ID)) u_dscr_regs_checker (
	.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
	.cmdData(cmdData), .byteAck(byteAck), .userChecksumBad(userChecksumBad),
	.factoryChecksumBad(factoryChecksumBad), .rdByte(rdByte), .rdByteValid(rdByteValid),
	.dacCode(dacCode), .pmbusEnable(pmbusEnable), .deviceLocked(deviceLocked),
	.powerDownMode(powerDownMode), .refEnable(refEnable), .outputSpan(outputSpan));
`default_nettype wire

// file: tb/dscr_host_model.sv
// Bus host model issuing commands and acknowledging read bytes
`timescale 1ns/1ps
`default_nettype none
module dscr_host_model (
	input  wire logic        clk_sys,
	input  wire logic        rdByteValid,
	output logic             cmdValid,
	output logic             cmdWrite,
	output logic [7:0]       cmdAddr,
	output logic [15:0]      cmdData,
	output logic             byteAck
);
	initial begin
		{cmdValid, cmdWrite, byteAck} = 3'h0;
		cmdAddr = 8'h00;
		cmdData = 16'h0000;
	end
	// One strobe cycle, then released lines scrambled
	task automatic issue(input logic wr, input logic [7:0] addr, input logic [15:0] data);
		@(negedge clk_sys);
		{cmdValid, cmdWrite, cmdAddr, cmdData} = {1'b1, wr, addr, data};
		@(negedge clk_sys);
		{cmdValid, cmdWrite, cmdAddr, cmdData} = {1'b0, ~wr, ~addr, ~data};
	endtask : issue
	task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
		issue(1'b1, addr, data);
	endtask : write_reg
	task automatic read_reg(input logic [7:0] addr);
		int n;
		issue(1'b0, addr, 16'h0000);
		for (n = 0; n < 8 && rdByteValid !== 1'b1; n++) @(negedge clk_sys);
		@(negedge clk_sys);
		byteAck = 1'b1;
		@(negedge clk_sys);
		byteAck = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : read_reg
endmodule : dscr_host_model
`default_nettype wire

// file: tb/tb_dscr_status_config_regs.sv
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
`default_nettype none
module tb_dscr_status_config_regs;
	localparam logic [3:0] PID = 4'ha;
	localparam logic [1:0] RID = 2'h2;
	logic        clk_sys, rst, cmdValid, cmdWrite, byteAck, rdByteValid;
	logic        userChecksumBad, factoryChecksumBad, pmbusEnable, deviceLocked, refEnable;
	logic [7:0]  cmdAddr, rdByte;
	logic [15:0] cmdData;
	logic [9:0]  dacCode;
	logic [1:0]  powerDownMode, outputSpan;
	logic [7:0]  expQ[$];
	int          failCount = 0;
	int          nTests = 0;
	int          cycles = 0;
	int          seed = 32'hdaa5e46d;

	dscr_host_model u_dscr_host_model (.clk_sys(clk_sys), .rdByteValid(rdByteValid),
		.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.byteAck(byteAck));
	dscr_status_config_regs #(.FAST_CYC(8), .MID_CYC(16), .SLOW_CYC(32), .NV_BUSY_CYC(20),
		.PART_ID(PID), .REVISION_ID(RID)) u_dscr_status_config_regs (.clk_sys(clk_sys),
		.rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
		.cmdData(cmdData), .byteAck(byteAck), .userChecksumBad(userChecksumBad),
		.factoryChecksumBad(factoryChecksumBad), .rdByte(rdByte), .rdByteValid(rdByteValid),
		.dacCode(dacCode), .pmbusEnable(pmbusEnable), .deviceLocked(deviceLocked),
		.powerDownMode(powerDownMode), .refEnable(refEnable), .outputSpan(outputSpan));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic print_verdict();
		$display("comparisons=%0d mismatches=%0d", nTests, failCount);
		if (failCount == 0 && nTests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic cmp_val(input logic [15:0] exp, input logic [15:0] got);
		nTests++;
		if (got !== exp) begin
			failCount++;
			$display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : cmp_val
	task automatic check_read(input logic [7:0] addr, input logic [15:0] exp);
		expQ.push_back(exp[15:8]);
		expQ.push_back(exp[7:0]);
		u_dscr_host_model.read_reg(addr);
	endtask : check_read
	task automatic wr(input logic [7:0] addr, input logic [15:0] data);
		u_dscr_host_model.write_reg(addr, data);
	endtask : wr
	function automatic logic [15:0] stat(input logic [3:0] flags);
		return {flags, 6'h00, PID, RID};
	endfunction : stat
	// Step relation between two samples of a running waveform
	function automatic logic waveOk(input logic [1:0] m, input logic [9:0] c, input logic [9:0] n);
		logic inRange;
		inRange = n >= 10'd8 && n <= 10'd20;
		case (m)
			2'd0: return inRange && (n == c + 10'd1 || n == c - 10'd1
				|| (n == c && (c == 10'd8 || c == 10'd20)));
			2'd1: return inRange && (n == c + 10'd1 || (c == 10'd20 && n == 10'd8));
			2'd2: return inRange && (n == c - 10'd1 || (c == 10'd8 && n == 10'd20));
			default: return inRange && n != c && (n == 10'd8 || n == 10'd20);
		endcase
	endfunction : waveOk

	// Each returned byte against the oldest note
	always @(posedge clk_sys) begin
		if (rdByteValid === 1'b1) cmp_val(expQ.size() ? {8'h00, expQ.pop_front()} : 16'hxxxx, {8'h00, rdByte});
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failCount++;
			print_verdict();
		end
	end

	initial begin
		logic [15:0] v, cfg;
		logic [9:0]  prev;
		logic        ok;
		rst = 1'b1;
		{userChecksumBad, factoryChecksumBad} = 2'b00;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		cmp_val(16'h0010, {9'h000, pmbusEnable, deviceLocked, powerDownMode, refEnable, outputSpan});
		check_read(8'hd1, 16'h01f0);
		check_read(8'h55, 16'h0000);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			{userChecksumBad, factoryChecksumBad} = i[1:0];
			wr(8'hd0, 16'($random(seed)));
			check_read(8'hd0, stat({i[1:0], 2'b00}));
		end
		{userChecksumBad, factoryChecksumBad} = 2'b00;
		$display("test status alarms done");
		v = 16'($random(seed));
		cfg = {v[15:14], 2'b01, v[11:9], 4'hf, v[4:0]};
		wr(8'hd1, cfg);
		check_read(8'hd1, cfg);
		cmp_val(16'h0001, {15'h0000, pmbusEnable});
		wr(8'h21, v);
		repeat (2) @(negedge clk_sys);
		cmp_val({6'h00, v[11:2]}, {6'h00, dacCode});
		$display("test config and code done");
		wr(8'hd1, cfg | 16'h2000);
		cmp_val(16'h0001, {15'h0000, deviceLocked});
		wr(8'hd1, 16'h01f0);
		wr(8'h21, ~v);
		check_read(8'hd1, cfg);
		cmp_val({6'h00, v[11:2]}, {6'h00, dacCode});
		wr(8'hd3, 16'h5000);
		cmp_val(16'h0000, {15'h0000, deviceLocked});
		check_read(8'hd1, cfg);
		$display("test lock done");
		wr(8'hd3, 16'h0010);
		check_read(8'hd0, stat(4'h2));
		wr(8'hd1, 16'h01f0);
		check_read(8'hd1, cfg);
		repeat (25) @(negedge clk_sys);
		check_read(8'hd0, stat(4'h0));
		wr(8'hd1, 16'h01f0);
		check_read(8'hd1, 16'h01f0);
		$display("test store busy done");
		wr(8'h21, 16'h0190);
		wr(8'hd1, 16'h0000);
		wr(8'h21, 16'h01a0);
		check_read(8'hd0, stat(4'h1));
		wr(8'hd1, 16'h01f0);
		check_read(8'hd1, 16'h0000);
		repeat (40) @(negedge clk_sys);
		check_read(8'hd0, stat(4'h0));
		cmp_val(16'd104, {6'h00, dacCode});
		$display("test update busy done");
		wr(8'hd1, 16'h01f0);
		wr(8'h25, 16'h0050);
		wr(8'h26, 16'h0020);
		for (int m = 0; m < 4; m++) begin
			wr(8'hd1, {m[1:0], 14'h01f0});
			wr(8'hd3, 16'h0100);
			repeat (5) @(negedge clk_sys);
			prev = dacCode;
			ok = 1'b1;
			repeat (30) begin
				@(negedge clk_sys);
				ok = ok & waveOk(m[1:0], prev, dacCode);
				prev = dacCode;
			end
			cmp_val(16'h0001, {15'h0000, ok});
			wr(8'hd3, 16'h0000);
			repeat (3) @(negedge clk_sys);
			cmp_val(16'd104, {6'h00, dacCode});
		end
		$display("test waveforms done");
		repeat (4) @(negedge clk_sys);
		if (expQ.size() != 0) cmp_val(16'h0000, 16'(expQ.size()));
		print_verdict();
	end
endmodule : tb_dscr_status_config_regs
`default_nettype wire
